// *** hw/srmc_params.svh ***
`ifndef SRMC_PARAMS_SVH
`define SRMC_PARAMS_SVH

// ************************************************************
// clock and speed grade figures, in ns
// ************************************************************
`define SRMC_CLK_PERIOD_NS      4
// the slowest grade is the default so that any part is met
`define SRMC_READ_PERIOD_MIN_NS 120
`define SRMC_OE_ACCESS_NS       60
`define SRMC_OE_FLOAT_NS        60
`define SRMC_CS_FLOAT_NS        50
`define SRMC_WRITE_OVERLAP_NS   90
`define SRMC_WRITE_CYCLE_NS     120
`define SRMC_CS_TO_END_NS       100
`define SRMC_ADDR_TO_END_NS     100
`define SRMC_WDATA_LEAD_NS      50
`define SRMC_FLOAT_AFTER_WS_NS  60
`define SRMC_RECOVERY_NS        10
`define SRMC_DRIVE_AFTER_END_NS 5

// all times round up to whole cycles, never below one cycle
`define SRMC_CYC_UP(ns)   ((((ns) + `SRMC_CLK_PERIOD_NS - 1) / `SRMC_CLK_PERIOD_NS) < 1 ? 1 : \
                           (((ns) + `SRMC_CLK_PERIOD_NS - 1) / `SRMC_CLK_PERIOD_NS))

// ************************************************************
// reset values of the pins
// ************************************************************
`define SRMC_ADDR_RESET  15'h0000
`define SRMC_DATA_RESET  8'h00

`endif

// *** hw/srmc_pkg.sv ***
package srmc_pkg;
  typedef enum logic [2:0] {
    SRMC_IDLE   = 3'b000,
    SRMC_RD_ACC = 3'b001,
    SRMC_RD_REL = 3'b010,
    SRMC_WR_STR = 3'b011,
    SRMC_WR_REC = 3'b100
  } srmc_state_t;

  typedef struct packed {
    logic        write;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } srmc_req_t;

  typedef struct packed {
    logic        select_n;
    logic        write_strobe_n;
    logic        output_drive_n;
  } srmc_ctl_t;
endpackage

// *** hw/srmc_sync.sv ***
`timescale 1ns/100ps
`include "srmc_params.svh"

// ************************************************************
// three-stage pin synchroniser, a change counts once stages agree
// ************************************************************
module srmc_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_sync <= '0;
    end else if (stage2 == stage3) begin
      o_sync <= stage3;
    end
  end
endmodule

// *** hw/srmc_ctrl.sv ***
`timescale 1ns/100ps
`include "srmc_params.svh"

// ************************************************************
// host-side controller for a 32k by 8 asynchronous static ram
// ************************************************************
// Behaviour
// - hold select and strobe low together for overlap; keep write cycle length
// - assert select long enough before end of write
// - address stable long enough before end of write
// - address stable by the later falling edge; never changes mid-write
// - write data leads end of write; address held for recovery afterwards
// - host never drives against the memory while it outputs
module srmc_ctrl
  import srmc_pkg::*;
#(
  parameter int ADDR_W = 15,
  parameter int DATA_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_req_valid,
  input  wire logic              i_req_write,
  input  wire logic [ADDR_W-1:0] i_req_addr,
  input  wire logic [DATA_W-1:0] i_req_wdata,
  output logic                   o_req_ready,
  output logic                   o_rdata_valid,
  output logic      [DATA_W-1:0] o_rdata,
  output logic      [ADDR_W-1:0] o_addr_lines,
  output logic                   o_device_select_n,
  output logic                   o_write_strobe_n,
  output logic                   o_output_drive_n,
  input  wire logic [DATA_W-1:0] i_data_bus,
  output logic      [DATA_W-1:0] o_data_bus,
  output logic                   o_data_bus_oe
);

  // ************************************************************
  // cycle counts
  // ************************************************************
  // sampling waits for access plus three sync stages and agreement
  localparam int SYNC_LAT   = 4;
  localparam int RD_ACC_CYC = `SRMC_CYC_UP(`SRMC_READ_PERIOD_MIN_NS) + SYNC_LAT;
  localparam int OE_ACC_CYC = `SRMC_CYC_UP(`SRMC_OE_ACCESS_NS);
  localparam int RD_REL_CYC = `SRMC_CYC_UP(`SRMC_OE_FLOAT_NS);
  localparam int WR_OVL_CYC = `SRMC_CYC_UP(`SRMC_WRITE_OVERLAP_NS);
  localparam int WR_CS_CYC  = `SRMC_CYC_UP(`SRMC_CS_TO_END_NS);
  localparam int WR_AD_CYC  = `SRMC_CYC_UP(`SRMC_ADDR_TO_END_NS);
  localparam int WR_DS_CYC  = `SRMC_CYC_UP(`SRMC_WDATA_LEAD_NS);
  localparam int WR_FL_CYC  = `SRMC_CYC_UP(`SRMC_FLOAT_AFTER_WS_NS);
  localparam int WR_REC_CYC = `SRMC_CYC_UP(`SRMC_RECOVERY_NS);
  localparam int WR_CYC_CYC = `SRMC_CYC_UP(`SRMC_WRITE_CYCLE_NS);
  localparam int MAX2A      = (WR_OVL_CYC > WR_CS_CYC) ? WR_OVL_CYC : WR_CS_CYC;
  localparam int MAX2B      = (WR_AD_CYC > WR_FL_CYC + WR_DS_CYC) ? WR_AD_CYC : WR_FL_CYC + WR_DS_CYC;
  localparam int WR_STR_CYC = (MAX2A > MAX2B) ? MAX2A : MAX2B;
  localparam int WR_TAIL    = WR_CYC_CYC - WR_STR_CYC;
  localparam int WR_REC_ALL = (WR_REC_CYC > WR_TAIL) ? WR_REC_CYC : WR_TAIL;
  localparam int CNT_W      = 8;

  localparam logic [CNT_W-1:0] RD_ACC_LAST = CNT_W'(RD_ACC_CYC - 1);
  localparam logic [CNT_W-1:0] RD_REL_LAST = CNT_W'(RD_REL_CYC - 1);
  localparam logic [CNT_W-1:0] WR_STR_LAST = CNT_W'(WR_STR_CYC - 1);
  // the drive enable is registered, so it is raised one count early to give the full data lead
  localparam logic [CNT_W-1:0] WR_DRV_AT   = CNT_W'(WR_FL_CYC - 1);
  localparam logic [CNT_W-1:0] WR_REC_LAST = CNT_W'(WR_REC_ALL - 1);

  // ************************************************************
  // state
  // ************************************************************
  srmc_state_t             state;
  srmc_state_t             next_state;
  logic        [CNT_W-1:0] count;
  srmc_req_t               req;
  srmc_ctl_t               ctl;
  logic        [DATA_W-1:0] bus_sync;
  logic                    count_done;

  srmc_sync #(
    .WIDTH (DATA_W)
  ) u_bus_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_data_bus),
    .o_sync    (bus_sync)
  );

  assign o_req_ready = (state == SRMC_IDLE);

  always_comb begin
    case (state)
      SRMC_RD_ACC: count_done = (count == RD_ACC_LAST);
      SRMC_RD_REL: count_done = (count == RD_REL_LAST);
      SRMC_WR_STR: count_done = (count == WR_STR_LAST);
      SRMC_WR_REC: count_done = (count == WR_REC_LAST);
      default:     count_done = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      SRMC_IDLE: begin
        if (i_req_valid) begin
          next_state = i_req_write ? SRMC_WR_STR : SRMC_RD_ACC;
        end
      end
      SRMC_RD_ACC: begin
        if (count_done) begin
          next_state = SRMC_RD_REL;
        end
      end
      SRMC_RD_REL: begin
        if (count_done) begin
          next_state = SRMC_IDLE;
        end
      end
      SRMC_WR_STR: begin
        if (count_done) begin
          next_state = SRMC_WR_REC;
        end
      end
      SRMC_WR_REC: begin
        if (count_done) begin
          next_state = SRMC_IDLE;
        end
      end
      default: next_state = SRMC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state <= SRMC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      count <= '0;
    end else if (next_state != state) begin
      count <= '0;
    end else if (state != SRMC_IDLE) begin
      count <= count + 1'b1;
    end
  end

  // address is latched at acceptance and held through recovery
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      req <= '{write: 1'b0, addr: `SRMC_ADDR_RESET, wdata: `SRMC_DATA_RESET};
    end else if (o_req_ready && i_req_valid) begin
      req <= '{write: i_req_write, addr: i_req_addr, wdata: i_req_wdata};
    end
  end

  // ************************************************************
  // pin control
  // ************************************************************
  // select and strobe fall together, on the same edge that loads the address
  // output drive stays high in writes so the memory never drives the bus
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ctl <= '{select_n: 1'b1, write_strobe_n: 1'b1, output_drive_n: 1'b1};
    end else begin
      case (next_state)
        SRMC_RD_ACC: ctl <= '{select_n: 1'b0, write_strobe_n: 1'b1, output_drive_n: 1'b0};
        SRMC_WR_STR: ctl <= '{select_n: 1'b0, write_strobe_n: 1'b0, output_drive_n: 1'b1};
        default:     ctl <= '{select_n: 1'b1, write_strobe_n: 1'b1, output_drive_n: 1'b1};
      endcase
    end
  end

  assign o_device_select_n = ctl.select_n;
  assign o_write_strobe_n  = ctl.write_strobe_n;
  assign o_output_drive_n  = ctl.output_drive_n;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_addr_lines <= `SRMC_ADDR_RESET;
    end else if (o_req_ready && i_req_valid) begin
      o_addr_lines <= i_req_addr;
    end
  end

  // host drives only after the memory's worst float time from strobe fall,
  // which still leaves the data lead before end of write
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_data_bus_oe <= 1'b0;
      o_data_bus    <= `SRMC_DATA_RESET;
    end else begin
      o_data_bus    <= req.wdata;
      o_data_bus_oe <= (state == SRMC_WR_STR) && (count >= WR_DRV_AT) && !count_done;
    end
  end

  // sample after full access time; the read release window then waits out
  // the memory's float before anyone may drive again
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata       <= `SRMC_DATA_RESET;
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata_valid <= (state == SRMC_RD_ACC) && count_done;
      if ((state == SRMC_RD_ACC) && count_done) begin
        o_rdata <= bus_sync;
      end
    end
  end
endmodule

// *** verification/srmc_ctrl_monitor.sv ***
`timescale 1ns/100ps
// ************************************
// write timing and bus ownership
// ************************************
module srmc_ctrl_monitor #(
  parameter int ADDR_W = 15,
  parameter int DATA_W = 8
) (
  input wire logic              i_clk,
  input wire logic              i_reset_n,
  input wire logic [ADDR_W-1:0] o_addr_lines,
  input wire logic              o_device_select_n,
  input wire logic              o_write_strobe_n,
  input wire logic              o_output_drive_n,
  input wire logic [DATA_W-1:0] o_data_bus,
  input wire logic              o_data_bus_oe
);
  // thresholds are grade times in 4 ns cycles, one less for the address, whose count lags a cycle; counters saturate so idle never wraps
  logic              wr;
  logic [7:0]        ovl;
  logic [7:0]        sel;
  logic [7:0]        acnt;
  logic [7:0]        dcnt;
  logic [ADDR_W-1:0] aq;
  logic [DATA_W-1:0] dq;
  assign wr = !o_device_select_n && !o_write_strobe_n;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  always_ff @(posedge i_clk) begin
    aq <= o_addr_lines;
    dq <= o_data_bus;
  end
  always_ff @(posedge i_clk) begin
    ovl  <= (!i_reset_n || !wr) ? 8'h00 : ovl + {7'h00, ~&ovl};
    sel  <= (!i_reset_n || o_device_select_n) ? 8'h00 : sel + {7'h00, ~&sel};
    acnt <= (!i_reset_n || o_addr_lines != aq) ? 8'h00 : acnt + {7'h00, ~&acnt};
    dcnt <= (!i_reset_n || !o_data_bus_oe || o_data_bus != dq) ? 8'h00 : dcnt + {7'h00, ~&dcnt};
  end
  // a reset cuts a write short, so only a write that ends out of reset is timed
  a_write_overlap: assert property ($fell(wr) && $past(i_reset_n) |-> ovl >= 8'h17)
    else $error("write overlap too short");
  a_select_lead: assert property ($fell(wr) && $past(i_reset_n) |-> sel >= 8'h19)
    else $error("select low too briefly before end of write");
  a_addr_lead: assert property ($fell(wr) && $past(i_reset_n) |-> acnt >= 8'h18)
    else $error("address not stable long enough before end of write");
  a_addr_still: assert property (wr && $past(wr) |-> $stable(o_addr_lines))
    else $error("address moved inside write");
  a_wdata_lead: assert property ($fell(wr) && $past(i_reset_n) |-> dcnt >= 8'h0d)
    else $error("write data lead too short");
  a_addr_recover: assert property ($fell(wr) && $past(i_reset_n) |-> $stable(o_addr_lines) [*3])
    else $error("address changed during recovery");
  a_no_clash: assert property (!o_output_drive_n |-> !o_data_bus_oe)
    else $error("host drives while memory outputs");
  a_drive_in_write: assert property (o_data_bus_oe |-> wr)
    else $error("host drives bus outside write");
endmodule

bind srmc_ctrl srmc_ctrl_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) srmc_ctrl_monitor_i (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .o_addr_lines(o_addr_lines),
  .o_device_select_n(o_device_select_n), .o_write_strobe_n(o_write_strobe_n),
  .o_output_drive_n(o_output_drive_n), .o_data_bus(o_data_bus), .o_data_bus_oe(o_data_bus_oe));

// *** verification/srmc_sram_model.sv ***
`timescale 1ns/100ps
// ************************************
// behavioural 32k by 8 static ram
// ************************************
module srmc_sram_model #(
  parameter int ACC_NS = 118
) (
  input  wire logic        i_clk,
  input  wire logic [14:0] i_addr_lines,
  input  wire logic        i_device_select_n,
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_output_drive_n,
  input  wire logic [7:0]  i_host_data,
  input  wire logic        i_host_oe,
  output logic      [7:0]  o_data_bus,
  output logic             o_clash
);
  logic [7:0] mem [0:32767];
  logic       rd;
  logic       wr;
  logic       drv = 1'b0;
  logic       ok  = 1'b0;
  logic       flt = 1'b0;
  assign rd = !i_device_select_n && !i_output_drive_n && i_write_strobe_n;
  assign wr = !i_device_select_n && !i_write_strobe_n;
  // turn-on is late, turn-off prompt; release means no drive at all
  always @(rd) drv <= #(rd ? 10 : 1) rd;
  // wrong data until the access time has run out
  always @(rd, i_addr_lines) begin
    ok <= #5 1'b0;
    ok <= #ACC_NS rd;
  end
  always @(posedge i_clk) begin
    flt <= ~flt;
    if (wr && i_host_oe) mem[i_addr_lines] <= i_host_data;
  end
  // a floating bus shows a changing pattern, not the last value
  always_comb begin
    if (i_host_oe) o_data_bus = i_host_data;
    else if (drv) o_data_bus = ok ? mem[i_addr_lines] : ~mem[i_addr_lines];
    else o_data_bus = flt ? 8'ha5 : 8'h5a;
  end
  assign o_clash = i_host_oe && drv;
endmodule

// *** verification/tb_srmc_ctrl.sv ***
`timescale 1ns/100ps
// ************************************
// scenario bench
// ************************************
module tb_srmc_ctrl;
  import srmc_pkg::*;
  logic        i_clk       = 1'b0;
  logic        i_reset_n   = 1'b0;
  logic        i_req_valid = 1'b0;
  srmc_req_t   rq          = '0;
  logic        rdy, rvalid, cs_n, we_n, oe_n, host_oe, clash;
  logic [7:0]  rdata, host_d, bus;
  logic [14:0] addr;
  int          bad_count   = 0;
  int          cmp_count   = 0;
  int          cycles      = 0;
  always #2 i_clk = ~i_clk;
  srmc_ctrl srmc_ctrl_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
    .i_req_write(rq.write), .i_req_addr(rq.addr), .i_req_wdata(rq.wdata), .o_req_ready(rdy),
    .o_rdata_valid(rvalid), .o_rdata(rdata), .o_addr_lines(addr), .o_device_select_n(cs_n),
    .o_write_strobe_n(we_n), .o_output_drive_n(oe_n), .i_data_bus(bus), .o_data_bus(host_d),
    .o_data_bus_oe(host_oe));
  srmc_sram_model srmc_sram_model_i (.i_clk(i_clk), .i_addr_lines(addr), .i_device_select_n(cs_n),
    .i_write_strobe_n(we_n), .i_output_drive_n(oe_n), .i_host_data(host_d), .i_host_oe(host_oe),
    .o_data_bus(bus), .o_clash(clash));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic bad, input string msg);
    cmp_count++;
    if (bad) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // a hang is cut short well past the few hundred cycles the scenarios need
  always @(posedge i_clk) begin
    cycles++;
    if (clash === 1'b1) chk(1'b1, "bus driven from both ends");
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic put(input srmc_req_t r);
    int n = 0;
    while (rdy !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    if (rdy !== 1'b1) chk(1'b1, "controller never ready");
    rq = r;
    i_req_valid = 1'b1;
    @(negedge i_clk);
    i_req_valid = 1'b0;
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    int n = 0;
    put({1'b0, a, 8'h00});
    while (rvalid !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    chk(rvalid !== 1'b1 || n < 30, "read cycle length");
    chk(rdata !== exp, "read data");
  endtask
  task automatic t_idle();
    chk({cs_n, we_n, oe_n, host_oe, rdy} !== 5'h1d, "idle pins");
  endtask
  task automatic t_table();
    logic [14:0] a [4] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h5555};
    logic [7:0]  d [4] = '{8'h00, 8'hff, 8'ha5, 8'h5a};
    for (int i = 0; i < 4; i++) put({1'b1, a[i], d[i]});
    for (int i = 0; i < 4; i++) rd(a[i], d[i]);
  endtask
  task automatic t_over();
    put({1'b1, 15'h1234, 8'h11});
    put({1'b1, 15'h1234, 8'hee});
    rd(15'h1234, 8'hee);
    rd(15'h7fff, 8'hff);
  endtask
  task automatic t_mid_reset();
    put({1'b1, 15'h0100, 8'h77});
    repeat (10) @(negedge i_clk);
    i_reset_n = 1'b0;
    @(negedge i_clk);
    i_reset_n = 1'b1;
    t_idle();
    put({1'b1, 15'h0100, 8'h3c});
    rd(15'h0100, 8'h3c);
  endtask
  initial begin
    repeat (3) @(negedge i_clk);
    i_reset_n = 1'b1;
    t_idle();
    t_table();
    t_over();
    t_mid_reset();
    wrap_up();
  end
endmodule
